// >>> shared/flash_keylock_consts.svh
// Purpose: offsets, field positions, codes and timing counts of the flash sequencer
// Assumes: apb byte addresses, 32-bit data, pclk at 20 MHz
// Notes:   definitions only
`ifndef FLASH_KEYLOCK_CONSTS_SVH
`define FLASH_KEYLOCK_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFS_FLASH_KEY      12'h000
`define OFS_STORE_CTRL     12'h004
`define OFS_FLASH_TIMING   12'h008
`define OFS_FLASH_STATUS   12'h00c

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define BIT_STORE_WE       0
`define BIT_STORE_EE       1
`define BIT_TIMING_WTE     0
`define BIT_STAT_BUSY      2
`define BIT_STAT_LOCKOUT   3
`define STORE_CTRL_RESET   2'h0
`define TIMING_RESET       1'h0

// ---------------------------------------------------------------
// key codes and memory geometry
// ---------------------------------------------------------------
`define KEY_CODE_FIRST     8'ha5
`define KEY_CODE_SECOND    8'hf1
`define SHORT_ADDR_LIMIT   16'h00ff
`define PAGE_LSB           9
`define ERASED_BYTE        8'hff

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS      50
`define PROG_TIME_NS       40000
`define ERASE_TIME_NS      20000000
`define PROG_CYCLES        ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ERASE_CYCLES       ((`ERASE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W            19

`endif

// >>> shared/flash_keylock_pkg.sv
// Purpose: types shared by the flash sequencer modules
// Assumes: nothing beyond the constants header
// Notes:   gray codes along the key sequence and on the steps into each operation
package flash_keylock_pkg;

  // ---------------------------------------------------------------
  // key lock states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    KEY_LOCKED  = 2'h0,
    KEY_FIRST   = 2'h1,
    KEY_ARMED   = 2'h3,
    KEY_LOCKOUT = 2'h2
  } key_state_type;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'h0,
    SEQ_READ  = 3'h1,
    SEQ_PROG  = 3'h3,
    SEQ_ERASE = 3'h2,
    SEQ_DONE  = 3'h6
  } seq_state_type;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        short_form;
  } move_write_type;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
    logic        erase;
  } debug_cmd_type;

  typedef struct packed {
    logic        prog;
    logic        erase;
    logic [15:0] addr;
    logic [6:0]  page;
    logic [7:0]  wdata;
  } flash_drive_type;

endpackage

// >>> core/flash_key_lock.sv
// Purpose: two-code lock and key for software flash modification
// Assumes: key writes and attempts are single-cycle pulses on pclk
// Notes:   lockout holds until presetn
`timescale 1ns/10ps
`include "flash_keylock_consts.svh"
module flash_key_lock
  import flash_keylock_pkg::*;
(
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // key register writes
  input  wire logic          key_wr,
  input  wire logic [7:0]    key_data,
  // flash operation events
  input  wire logic          attempt,
  input  wire logic          op_done,
  // state
  output key_state_type      key_state,
  output logic               armed
);

  key_state_type state_ff;
  key_state_type nxt_state;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      KEY_LOCKED: begin
        if (attempt) begin
          nxt_state = KEY_LOCKOUT;
        end else if (key_wr) begin
          nxt_state = (key_data == `KEY_CODE_FIRST) ? KEY_FIRST : KEY_LOCKOUT;
        end
      end
      KEY_FIRST: begin
        if (attempt) begin
          nxt_state = KEY_LOCKOUT;
        end else if (key_wr) begin
          nxt_state = (key_data == `KEY_CODE_SECOND) ? KEY_ARMED : KEY_LOCKOUT;
        end
      end
      KEY_ARMED: begin
        if (op_done) begin
          nxt_state = KEY_LOCKED;
        end else if (key_wr) begin
          nxt_state = KEY_LOCKOUT;
        end
      end
      default: begin
        nxt_state = KEY_LOCKOUT;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= KEY_LOCKED;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign key_state = state_ff;
  assign armed     = (state_ff == KEY_ARMED);

endmodule

// >>> core/flash_op_timer.sv
// Purpose: times one program or erase operation
// Assumes: start is a one-cycle pulse while idle
// Notes:   done pulses in the last busy cycle, while the count is one
`timescale 1ns/10ps
`include "flash_keylock_consts.svh"
module flash_op_timer (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // control
  input  wire logic                  start,
  input  wire logic [`TIMER_W-1:0]   cycles,
  // status
  output logic                       busy,
  output logic                       done
);

  logic [`TIMER_W-1:0] count_ff;
  logic [`TIMER_W-1:0] nxt_count;
  logic                busy_ff;
  logic                nxt_busy;

  always_comb begin
    nxt_count = count_ff;
    nxt_busy  = busy_ff;
    if (start) begin
      nxt_count = cycles;
      nxt_busy  = 1'b1;
    end else if (busy_ff) begin
      if (count_ff <= `TIMER_W'(1)) begin
        nxt_busy = 1'b0;
      end
      nxt_count = count_ff - `TIMER_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
      busy_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      busy_ff  <= nxt_busy;
    end
  end

  assign busy = busy_ff;
  assign done = busy_ff & (count_ff <= `TIMER_W'(1));

endmodule

// >>> core/flash_program_erase_keylock.sv
// Purpose: software and debug-port program / page erase of program flash
// Assumes: apb master on pclk; move writes and debug commands on pclk
// Notes:   flash macro is driven by level strobes held for the timed span
//
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "flash_keylock_consts.svh"
module flash_program_erase_keylock
  import flash_keylock_pkg::*;
#(
  parameter logic [`TIMER_W-1:0] ERASE_CYCLES = `TIMER_W'(`ERASE_CYCLES)
) (
  // clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // move writes from the core
  input  move_write_type     move_wr,
  output logic               core_stall,
  // data memory side
  output logic               xram_we,
  output logic [15:0]        xram_addr,
  output logic [7:0]         xram_wdata,
  // two-wire debug port commands
  input  debug_cmd_type      dbg_cmd,
  output logic               dbg_busy,
  // flash macro
  output logic [15:0]        flash_rd_addr,
  input  wire logic [7:0]    flash_rd_data,
  output flash_drive_type    flash_drv
);

  // ---------------------------------------------------------------
  // apb register file
  // ---------------------------------------------------------------
  logic        setup_phase;
  logic        access_phase;
  logic        addr_hit;
  logic        wr_key;
  logic        wr_ctrl;
  logic        wr_timing;
  logic        store_we_ff;
  logic        store_ee_ff;
  logic        timing_en_ff;
  logic        nxt_store_we;
  logic        nxt_store_ee;
  logic        nxt_timing_en;
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        slverr_ff;
  logic        nxt_slverr;

  key_state_type key_state;
  logic          key_armed;
  seq_state_type state_ff;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_key       = access_phase & pwrite & (paddr == `OFS_FLASH_KEY);
  assign wr_ctrl      = access_phase & pwrite & (paddr == `OFS_STORE_CTRL);
  assign wr_timing    = access_phase & pwrite & (paddr == `OFS_FLASH_TIMING);

  always_comb begin
    addr_hit = 1'b0;
    if (paddr == `OFS_FLASH_KEY) begin
      addr_hit = 1'b1;
    end else if (paddr == `OFS_STORE_CTRL) begin
      addr_hit = 1'b1;
    end else if (paddr == `OFS_FLASH_TIMING) begin
      addr_hit = 1'b1;
    end else if (paddr == `OFS_FLASH_STATUS) begin
      addr_hit = 1'b1;
    end
  end

  always_comb begin
    nxt_store_we  = store_we_ff;
    nxt_store_ee  = store_ee_ff;
    nxt_timing_en = timing_en_ff;
    nxt_prdata    = prdata_ff;
    nxt_slverr    = slverr_ff;
    // enable bits hold until software rewrites them
    if (wr_ctrl) begin
      nxt_store_we = pwdata[`BIT_STORE_WE];
      nxt_store_ee = pwdata[`BIT_STORE_EE];
    end
    if (wr_timing) begin
      nxt_timing_en = pwdata[`BIT_TIMING_WTE];
    end
    // read data and error are prepared in the setup cycle
    if (setup_phase) begin
      nxt_slverr = ~addr_hit;
      nxt_prdata = 32'h0;
      if (pwrite) begin
        nxt_prdata = 32'h0;
      end else if (paddr == `OFS_FLASH_KEY) begin
        nxt_prdata = {30'h0, key_state};
      end else if (paddr == `OFS_STORE_CTRL) begin
        nxt_prdata = {30'h0, store_ee_ff, store_we_ff};
      end else if (paddr == `OFS_FLASH_TIMING) begin
        nxt_prdata = {31'h0, timing_en_ff};
      end else if (paddr == `OFS_FLASH_STATUS) begin
        nxt_prdata = {28'h0, (key_state == KEY_LOCKOUT), (state_ff != SEQ_IDLE), key_state};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_we_ff  <= 1'b0;
      store_ee_ff  <= 1'b0;
      timing_en_ff <= `TIMING_RESET;
      prdata_ff    <= 32'h0;
      slverr_ff    <= 1'b0;
    end else begin
      store_we_ff  <= nxt_store_we;
      store_ee_ff  <= nxt_store_ee;
      timing_en_ff <= nxt_timing_en;
      prdata_ff    <= nxt_prdata;
      slverr_ff    <= nxt_slverr;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = access_phase & slverr_ff;

  // ---------------------------------------------------------------
  // move write routing
  // ---------------------------------------------------------------
  logic sw_flash_req;
  logic sw_short_blocked;
  logic sw_go;
  logic attempt;
  logic dbg_go;

  // short-address form above the limit never reaches flash
  assign sw_short_blocked = move_wr.short_form & (move_wr.addr > `SHORT_ADDR_LIMIT);
  assign sw_flash_req     = move_wr.valid & store_we_ff & ~sw_short_blocked
                            & (state_ff == SEQ_IDLE);
  assign sw_go            = sw_flash_req & key_armed & timing_en_ff;
  assign attempt          = sw_flash_req & ~key_armed;
  assign dbg_go           = dbg_cmd.valid & (state_ff == SEQ_IDLE)
                            & ~(move_wr.valid & store_we_ff);

  logic        xram_we_ff;
  logic [15:0] xram_addr_ff;
  logic [7:0]  xram_wdata_ff;
  logic        nxt_xram_we;
  logic [15:0] nxt_xram_addr;
  logic [7:0]  nxt_xram_wdata;

  always_comb begin
    nxt_xram_we    = 1'b0;
    nxt_xram_addr  = xram_addr_ff;
    nxt_xram_wdata = xram_wdata_ff;
    if (move_wr.valid & (~store_we_ff | sw_short_blocked) & ~core_stall) begin
      nxt_xram_we    = 1'b1;
      nxt_xram_addr  = move_wr.addr;
      nxt_xram_wdata = move_wr.data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xram_we_ff    <= 1'b0;
      xram_addr_ff  <= 16'h0;
      xram_wdata_ff <= 8'h0;
    end else begin
      xram_we_ff    <= nxt_xram_we;
      xram_addr_ff  <= nxt_xram_addr;
      xram_wdata_ff <= nxt_xram_wdata;
    end
  end

  assign xram_we    = xram_we_ff;
  assign xram_addr  = xram_addr_ff;
  assign xram_wdata = xram_wdata_ff;

  // ---------------------------------------------------------------
  // operation sequencer
  // ---------------------------------------------------------------
  seq_state_type   nxt_state;
  logic [15:0]     op_addr_ff;
  logic [15:0]     nxt_op_addr;
  logic [7:0]      op_data_ff;
  logic [7:0]      nxt_op_data;
  logic            op_erase_ff;
  logic            nxt_op_erase;
  logic            op_sw_ff;
  logic            nxt_op_sw;
  flash_drive_type drv_ff;
  flash_drive_type nxt_drv;
  logic            timer_start;
  logic [`TIMER_W-1:0] timer_cycles;
  logic            timer_done;
  logic            key_consume;

  always_comb begin
    nxt_state    = state_ff;
    nxt_op_addr  = op_addr_ff;
    nxt_op_data  = op_data_ff;
    nxt_op_erase = op_erase_ff;
    nxt_op_sw    = op_sw_ff;
    nxt_drv      = drv_ff;
    timer_start  = 1'b0;
    timer_cycles = `TIMER_W'(`PROG_CYCLES);
    key_consume  = 1'b0;
    case (state_ff)
      SEQ_IDLE: begin
        if (sw_go) begin
          nxt_op_addr  = move_wr.addr;
          nxt_op_data  = move_wr.data;
          nxt_op_erase = store_ee_ff;
          nxt_op_sw    = 1'b1;
          nxt_state    = store_ee_ff ? SEQ_ERASE : SEQ_READ;
        end else if (dbg_go) begin
          nxt_op_addr  = dbg_cmd.addr;
          nxt_op_data  = dbg_cmd.data;
          nxt_op_erase = dbg_cmd.erase;
          nxt_op_sw    = 1'b0;
          nxt_state    = dbg_cmd.erase ? SEQ_ERASE : SEQ_READ;
        end
      end
      SEQ_READ: begin
        // the merge keeps every cleared bit cleared
        nxt_drv.prog  = 1'b1;
        nxt_drv.addr  = op_addr_ff;
        nxt_drv.wdata = flash_rd_data & op_data_ff;
        timer_start   = 1'b1;
        timer_cycles  = `TIMER_W'(`PROG_CYCLES);
        nxt_state     = SEQ_PROG;
      end
      SEQ_PROG, SEQ_ERASE: begin
        if (state_ff == SEQ_ERASE && !drv_ff.erase) begin
          nxt_drv.erase = 1'b1;
          nxt_drv.page  = op_addr_ff[15:`PAGE_LSB];
          nxt_drv.addr  = {op_addr_ff[15:`PAGE_LSB], `PAGE_LSB'(0)};
          nxt_drv.wdata = `ERASED_BYTE;
          timer_start   = 1'b1;
          timer_cycles  = ERASE_CYCLES;
        end else if (timer_done) begin
          nxt_drv.prog  = 1'b0;
          nxt_drv.erase = 1'b0;
          nxt_state     = SEQ_DONE;
        end
      end
      SEQ_DONE: begin
        key_consume = op_sw_ff;
        nxt_state   = SEQ_IDLE;
      end
      default: begin
        nxt_state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= SEQ_IDLE;
      op_addr_ff  <= 16'h0;
      op_data_ff  <= 8'h0;
      op_erase_ff <= 1'b0;
      op_sw_ff    <= 1'b0;
      drv_ff      <= '0;
    end else begin
      state_ff    <= nxt_state;
      op_addr_ff  <= nxt_op_addr;
      op_data_ff  <= nxt_op_data;
      op_erase_ff <= nxt_op_erase;
      op_sw_ff    <= nxt_op_sw;
      drv_ff      <= nxt_drv;
    end
  end

  assign flash_drv     = drv_ff;
  assign flash_rd_addr = op_addr_ff;
  // the accepting cycle stalls too, so the core never issues a second move
  assign core_stall    = (state_ff != SEQ_IDLE) | sw_go;
  assign dbg_busy      = (state_ff != SEQ_IDLE);

  // ---------------------------------------------------------------
  // key lock and timer
  // ---------------------------------------------------------------
  flash_key_lock u_key_lock (
    .pclk      (pclk),
    .presetn   (presetn),
    .key_wr    (wr_key),
    .key_data  (pwdata[7:0]),
    .attempt   (attempt),
    .op_done   (key_consume),
    .key_state (key_state),
    .armed     (key_armed)
  );

  flash_op_timer u_op_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (timer_start),
    .cycles  (timer_cycles),
    .busy    (),
    .done    (timer_done)
  );

endmodule

// >>> sim/flash_macro_model.sv
// Purpose: behavioural flash array on the far side of the sequencer
// Assumes: drive strobes are levels sampled on pclk
// Notes:   read is combinational; cells only clear when programmed
`timescale 1ns/10ps
module flash_macro_model
  import flash_keylock_pkg::*;
(
  // clock
  input  wire logic        pclk,
  // macro side
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data,
  input  flash_drive_type  drv
);
  logic [7:0] mem [65536];

  initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 37 + 5);

  assign rd_data = mem[rd_addr];

  always @(posedge pclk) begin
    if (drv.prog) mem[drv.addr] <= mem[drv.addr] & drv.wdata;
    if (drv.erase) for (int i = 0; i < 512; i++) mem[{drv.page, 9'(i)}] <= 8'hff;
  end
endmodule

// >>> sim/flash_program_erase_keylock_checker.sv
// Purpose: port-level properties of the flash sequencer
// Assumes: one clock domain, presetn async active low
// Notes:   bound to the top module
`timescale 1ns/10ps
`include "flash_keylock_consts.svh"
module flash_program_erase_keylock_checker
  import flash_keylock_pkg::*;
#(
  parameter logic [`TIMER_W-1:0] ERASE_CYCLES = `TIMER_W'(`ERASE_CYCLES)
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // core side
  input  move_write_type   move_wr,
  input  wire logic        core_stall,
  input  wire logic        xram_we,
  input  wire logic [15:0] xram_addr,
  input  wire logic [7:0]  xram_wdata,
  input  wire logic        dbg_busy,
  // flash macro
  input  wire logic [15:0] flash_rd_addr,
  input  wire logic [7:0]  flash_rd_data,
  input  flash_drive_type  flash_drv
);
  localparam int PROG_N = `PROG_CYCLES;
  logic [`TIMER_W-1:0] span_ff;
  logic [`TIMER_W-1:0] nxt_span;

  // ---------------------------------------------------------------
  // strobe length counter
  // ---------------------------------------------------------------
  always_comb nxt_span = (flash_drv.prog || flash_drv.erase) ? span_ff + 1'b1 : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) span_ff <= '0;
    else span_ff <= nxt_span;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  a_prog_span: assert property ($fell(flash_drv.prog) |-> span_ff == PROG_N)
    else $error("program strobe length wrong");
  a_erase_span: assert property ($fell(flash_drv.erase) |-> span_ff == ERASE_CYCLES)
    else $error("erase strobe length wrong");
  a_stall_during: assert property (flash_drv.prog || flash_drv.erase |-> core_stall)
    else $error("core not stalled during operation");
  a_prog_clears: assert property ($rose(flash_drv.prog) && flash_rd_addr == flash_drv.addr
    |-> (flash_drv.wdata & ~flash_rd_data) == 8'h00) else $error("program sets a bit");
  a_one_op: assert property (!(flash_drv.prog && flash_drv.erase))
    else $error("program and erase together");
  a_drive_stable: assert property (flash_drv.prog && $past(flash_drv.prog)
    |-> $stable(flash_drv.addr) && $stable(flash_drv.wdata)) else $error("program drive moved");
  a_xram_copy: assert property (xram_we |-> $past(move_wr.valid) &&
    xram_addr == $past(move_wr.addr) && xram_wdata == $past(move_wr.data))
    else $error("data memory write not a copy of the move");
  a_short_xram: assert property (move_wr.valid && move_wr.short_form &&
    move_wr.addr > 16'h00ff && !dbg_busy |=> xram_we) else $error("short move reached flash");
  a_idle_after: assert property ($fell(flash_drv.prog) || $fell(flash_drv.erase)
    |-> ##[1:2] !dbg_busy) else $error("sequencer stays busy");

  c_prog: cover property ($rose(flash_drv.prog));
  c_erase: cover property ($rose(flash_drv.erase));
  c_xram: cover property (xram_we);
endmodule

bind flash_program_erase_keylock flash_program_erase_keylock_checker #(
  .ERASE_CYCLES(ERASE_CYCLES)
) chk (
  .pclk(pclk), .presetn(presetn), .move_wr(move_wr), .core_stall(core_stall),
  .xram_we(xram_we), .xram_addr(xram_addr), .xram_wdata(xram_wdata), .dbg_busy(dbg_busy),
  .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .flash_drv(flash_drv)
);

// >>> sim/flash_program_erase_keylock_bench.sv
// Purpose: self-checking bench of the flash sequencer
// Assumes: zero-wait apb slave, short erase count
// Notes:   expected flash image is kept in the bench
`timescale 1ns/10ps
`include "flash_keylock_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module flash_program_erase_keylock_bench
  import flash_keylock_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, core_stall, xram_we, dbg_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] xram_addr, flash_rd_addr, xa;
  logic [7:0] xram_wdata, flash_rd_data, d;
  move_write_type move_wr;
  debug_cmd_type dbg_cmd;
  flash_drive_type flash_drv;
  int num_errors = 0, num_checks = 0, cyc = 0, seed, exp_mem [65536];
  logic e;

  flash_program_erase_keylock #(.ERASE_CYCLES(19'd20)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .move_wr(move_wr), .core_stall(core_stall), .xram_we(xram_we), .xram_addr(xram_addr),
    .xram_wdata(xram_wdata), .dbg_cmd(dbg_cmd), .dbg_busy(dbg_busy),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .flash_drv(flash_drv));
  flash_macro_model mdl (.pclk(pclk), .rd_addr(flash_rd_addr), .rd_data(flash_rd_data),
    .drv(flash_drv));

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (xram_we === 1'b1) xa <= xram_addr;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic key;
    apb(1, `OFS_FLASH_KEY, `KEY_CODE_FIRST);
    apb(1, `OFS_FLASH_KEY, `KEY_CODE_SECOND);
  endtask

  task automatic idle_wait;
    repeat (3) @(posedge pclk);
    for (int i = 0; i < 2000 && dbg_busy !== 1'b0; i++) @(posedge pclk);
    `CHK(dbg_busy, 1'b0)
    @(posedge pclk);
  endtask

  task automatic mv(input logic [15:0] a, input logic [7:0] dd, input logic s);
    @(posedge pclk);
    move_wr <= '{1'b1, a, dd, s};
    @(posedge pclk);
    move_wr.valid <= 1'b0;
    idle_wait();
  endtask

  task automatic dbg(input logic [15:0] a, input logic [7:0] dd, input logic er);
    @(posedge pclk);
    dbg_cmd <= '{1'b1, a, dd, er};
    for (int i = 0; i < 50 && dbg_busy !== 1'b1; i++) @(posedge pclk);
    `CHK(dbg_busy, 1'b1)
    dbg_cmd.valid <= 1'b0;
    idle_wait();
  endtask

  task automatic chk_rng(input int lo, input int n);
    for (int i = lo; i < lo + n; i++) `CHK(mdl.mem[i], 8'(exp_mem[i]))
  endtask

  task automatic erase_exp(input int pg);
    for (int i = 0; i < 512; i++) exp_mem[pg * 512 + i] = 255;
  endtask

  initial begin
    seed = 32'hf80f;
    {presetn, psel, penable, pwrite, paddr, pwdata, move_wr, dbg_cmd} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 65536; i++) exp_mem[i] = mdl.mem[i];
    apb(0, `OFS_FLASH_STATUS, 0);
    `CHK(q, 32'h0)
    apb(0, 12'h010, 0);
    `CHK({e, q}, 33'h100000000)
    apb(1, `OFS_FLASH_TIMING, 1);
    apb(1, `OFS_STORE_CTRL, 3);
    apb(1, `OFS_FLASH_KEY, `KEY_CODE_FIRST);
    apb(0, `OFS_FLASH_KEY, 0);
    `CHK(q[1:0], 2'h1)
    repeat (7) @(posedge pclk);
    apb(1, `OFS_FLASH_KEY, `KEY_CODE_SECOND);
    apb(0, `OFS_FLASH_KEY, 0);
    `CHK(q[1:0], 2'h3)
    mv(16'h0234, 8'($random(seed)), 1'b0);
    erase_exp(1);
    chk_rng(16'h01ff, 514);
    apb(0, `OFS_FLASH_KEY, 0);
    `CHK(q[1:0], 2'h0)
    apb(1, `OFS_STORE_CTRL, 0);
    apb(0, `OFS_STORE_CTRL, 0);
    `CHK(q[1:0], 2'h0)
    apb(1, `OFS_STORE_CTRL, 1);
    for (int k = 0; k < 2; k++) begin
      d = 8'($random(seed));
      key();
      mv(16'h0240, d, 1'b0);
      exp_mem[16'h0240] &= d;
      chk_rng(16'h023f, 3);
    end
    apb(1, `OFS_FLASH_TIMING, 0);
    key();
    mv(16'h0250, 8'h00, 1'b0);
    chk_rng(16'h0250, 1);
    apb(1, `OFS_FLASH_TIMING, 1);
    mv(16'h0300, 8'h00, 1'b1);
    `CHK(xa, 16'h0300)
    chk_rng(16'h0300, 1);
    mv(16'h0080, 8'h3c, 1'b1);
    exp_mem[16'h0080] &= 8'h3c;
    chk_rng(16'h0080, 1);
    apb(1, `OFS_STORE_CTRL, 0);
    mv(16'h0260, 8'h00, 1'b0);
    `CHK(xa, 16'h0260)
    chk_rng(16'h0260, 1);
    apb(1, `OFS_STORE_CTRL, 1);
    mv(16'h0270, 8'h00, 1'b0);
    apb(0, `OFS_FLASH_STATUS, 0);
    `CHK(q[3:0], 4'ha)
    key();
    mv(16'h0270, 8'h00, 1'b0);
    chk_rng(16'h0270, 1);
    dbg(16'h0270, 8'h00, 1'b0);
    exp_mem[16'h0270] = 0;
    dbg(16'h0400, 8'h00, 1'b1);
    erase_exp(2);
    chk_rng(16'h0270, 1);
    chk_rng(16'h03ff, 514);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      if (k > 0) apb(1, `OFS_FLASH_KEY, `KEY_CODE_FIRST);
      apb(1, `OFS_FLASH_KEY, k == 1 ? 8'h00 : k == 2 ? 8'ha5 : `KEY_CODE_SECOND);
      apb(0, `OFS_FLASH_STATUS, 0);
      `CHK(q[3:0], 4'ha)
    end
    test_done();
  end
endmodule
